// *** rtl/scel_pkg.sv ***
// What this block does
// - keep last 100 error entries, drop oldest
// - clear history command empties error list
// - three counters: motor hours, drives, doors
// - per-counter interval, due shown on output
// - reload command copies interval into remaining
// - lifetime totals read-only, cleared only by rst_i
// - current counts read-only, count since clear
// - remaining values read-only, show left count
// - motor interval programmable 0 to 9999
// - drive and door intervals 0 to 99999
// - statistics reset clears drive, call statistics
// - error forwarding enable gates all messages
// - new error makes led flash or stay off
package scel_pkg;
   localparam int CNT_W = 32;
   localparam int HIST_DEPTH = 100;
   localparam int HIST_AW = 7;
   localparam int CODE_W = 16;
   localparam logic [16:0] MOTOR_IVL_MAX = 17'd9999;
   localparam logic [16:0] EVT_IVL_MAX = 17'd99999;
   localparam logic [16:0] IVL_RESET = 17'h00000;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CMD = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   localparam logic [7:0] ADDR_IVL0 = 8'h14;
   localparam logic [7:0] ADDR_TOTAL0 = 8'h20;
   localparam logic [7:0] ADDR_CUR0 = 8'h2C;
   localparam logic [7:0] ADDR_REM0 = 8'h38;
   localparam logic [7:0] ADDR_HIST_CNT = 8'h44;
   localparam logic [7:0] ADDR_HIST_IDX = 8'h48;
   localparam logic [7:0] ADDR_HIST_DATA = 8'h4C;
   localparam logic [7:0] ADDR_CALLS = 8'h50;
   localparam logic [7:0] ADDR_DRIVES_STAT = 8'h54;
   localparam int CTRL_FWD_EN = 0;
   localparam int CTRL_LED_FLASH = 1;
   localparam int CMD_CLR_HIST = 0;
   localparam int CMD_CLR_CUR = 1;
   localparam int CMD_RELOAD = 2;
   localparam int CMD_STAT_RST = 3;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam int IRQ_W = 4;
   localparam int FLASH_W = 23;
   typedef struct packed {
      logic motor_tick;
      logic drive_done;
      logic door_move;
      logic call_taken;
   } scel_evt_t;
   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
   } scel_err_t;
endpackage

// *** rtl/scel_top.sv ***
// Chosen here: the address map and the Avalon-MM register port.
module scel_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire scel_pkg::scel_evt_t evt_i,
   input wire scel_pkg::scel_err_t err_i,
   output logic [2:0] service_due_o,
   output logic err_fwd_valid_o,
   output logic [scel_pkg::CODE_W-1:0] err_fwd_code_o,
   output logic err_led_o,
   output logic irq_o
);
   localparam int W = scel_pkg::CNT_W;
   typedef logic [W-1:0] scel_word_t;

   scel_word_t total_q [3], total_d [3];
   scel_word_t cur_q [3], cur_d [3];
   scel_word_t rem_q [3], rem_d [3];
   logic [16:0] ivl_q [3], ivl_d [3];
   logic [scel_pkg::CODE_W-1:0] hist_q [scel_pkg::HIST_DEPTH];
   logic [scel_pkg::CODE_W-1:0] hist_d [scel_pkg::HIST_DEPTH];
   logic [scel_pkg::HIST_AW-1:0] hcnt_q, hcnt_d, hidx_q, hidx_d;
   scel_word_t calls_q, calls_d, dstat_q, dstat_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic [scel_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
   logic [scel_pkg::FLASH_W-1:0] flash_q, flash_d;
   logic led_arm_q, led_arm_d, led_q, led_d;
   logic [2:0] due_q, due_d;
   logic fwd_v_q, fwd_v_d;
   logic [scel_pkg::CODE_W-1:0] fwd_c_q, fwd_c_d;
   logic [31:0] rdata_q, rdata_d;
   logic ack_q, ack_d;
   logic irq_q, irq_d;
   logic [2:0] evt;
   logic wr, rd;
   logic [3:0] cmd;
   logic [16:0] wv;
   logic [7:0] a;

   assign evt = {evt_i.door_move, evt_i.drive_done, evt_i.motor_tick};
   // one wait state: request answered on the second edge
   assign wr = avs_write_i && !ack_q;
   assign rd = avs_read_i && !ack_q;
   assign a = avs_address_i;
   assign cmd = (wr && a == scel_pkg::ADDR_CMD) ? avs_writedata_i[3:0]
      : 4'h0;
   assign wv = avs_writedata_i[16:0];

   always_comb begin
      logic [2:0] due_rise;
      logic new_err;
      due_rise = 3'h0;
      new_err = err_i.valid;
      ack_d = (avs_read_i || avs_write_i) && !ack_q;
      ctrl_d = ctrl_q;
      imask_d = imask_q;
      hidx_d = hidx_q;
      calls_d = calls_q;
      dstat_d = dstat_q;
      for (int i = 0; i < 3; i++) begin
         total_d[i] = total_q[i] + scel_word_t'(evt[i]);
         cur_d[i] = cur_q[i] + scel_word_t'(evt[i]);
         rem_d[i] = rem_q[i];
         if (evt[i] && rem_q[i] != '0) begin
            rem_d[i] = rem_q[i] - scel_word_t'(1);
         end
         if (cmd[scel_pkg::CMD_CLR_CUR]) begin
            cur_d[i] = '0;
         end
         if (cmd[scel_pkg::CMD_RELOAD]) begin
            rem_d[i] = scel_word_t'(ivl_q[i]);
         end
         ivl_d[i] = ivl_q[i];
         if (wr && a == scel_pkg::ADDR_IVL0 + 8'(4 * i)) begin
            if (i == 0) begin
               ivl_d[i] = (avs_writedata_i >
                  32'(scel_pkg::MOTOR_IVL_MAX)) ?
                  scel_pkg::MOTOR_IVL_MAX : wv;
            end else begin
               ivl_d[i] = (avs_writedata_i >
                  32'(scel_pkg::EVT_IVL_MAX)) ?
                  scel_pkg::EVT_IVL_MAX : wv;
            end
         end
         due_d[i] = (rem_d[i] == '0);
         due_rise[i] = due_d[i] && !due_q[i];
      end
      if (evt_i.call_taken) begin
         calls_d = calls_q + scel_word_t'(1);
      end
      if (evt_i.drive_done) begin
         dstat_d = dstat_q + scel_word_t'(1);
      end
      if (cmd[scel_pkg::CMD_STAT_RST]) begin
         calls_d = '0;
         dstat_d = '0;
      end
      // history: newest at 0, oldest falls off the end
      hist_d = hist_q;
      hcnt_d = hcnt_q;
      if (new_err) begin
         hist_d[0] = err_i.code;
         for (int j = 1; j < scel_pkg::HIST_DEPTH; j++) begin
            hist_d[j] = hist_q[j-1];
         end
         if (hcnt_q != 7'(scel_pkg::HIST_DEPTH)) begin
            hcnt_d = hcnt_q + 7'h01;
         end
      end
      if (cmd[scel_pkg::CMD_CLR_HIST]) begin
         hcnt_d = '0;
      end
      fwd_v_d = new_err && ctrl_q[scel_pkg::CTRL_FWD_EN];
      fwd_c_d = new_err ? err_i.code : fwd_c_q;
      led_arm_d = led_arm_q;
      if (new_err) begin
         led_arm_d = ctrl_q[scel_pkg::CTRL_LED_FLASH];
      end
      if (cmd[scel_pkg::CMD_CLR_HIST] || !ctrl_q[scel_pkg::CTRL_LED_FLASH])
      begin
         led_arm_d = 1'b0;
      end
      flash_d = flash_q + {{(scel_pkg::FLASH_W-1){1'b0}}, 1'b1};
      led_d = led_arm_q && flash_q[scel_pkg::FLASH_W-1];
      if (wr) begin
         unique case (a)
            scel_pkg::ADDR_CTRL: ctrl_d = avs_writedata_i[1:0];
            scel_pkg::ADDR_IRQ_MASK: imask_d = avs_writedata_i[3:0];
            scel_pkg::ADDR_HIST_IDX: hidx_d = avs_writedata_i[6:0];
            default: ;
         endcase
      end
      // sticky status; set wins over write-one-to-clear
      ist_d = ist_q;
      if (wr && a == scel_pkg::ADDR_IRQ_STAT) begin
         ist_d = ist_q & ~avs_writedata_i[3:0];
      end
      ist_d = ist_d | {new_err, due_rise[2], due_rise[1], due_rise[0]};
      irq_d = |(ist_d & imask_d);
      rdata_d = rdata_q;
      if (rd) begin
         rdata_d = 32'h0;
         for (int k = 0; k < 3; k++) begin
            if (a == scel_pkg::ADDR_IVL0 + 8'(4 * k)) begin
               rdata_d = {15'h0, ivl_q[k]};
            end
            if (a == scel_pkg::ADDR_TOTAL0 + 8'(4 * k)) begin
               rdata_d = total_q[k];
            end
            if (a == scel_pkg::ADDR_CUR0 + 8'(4 * k)) begin
               rdata_d = cur_q[k];
            end
            if (a == scel_pkg::ADDR_REM0 + 8'(4 * k)) begin
               rdata_d = rem_q[k];
            end
         end
         unique case (a)
            scel_pkg::ADDR_CTRL: rdata_d = {30'h0, ctrl_q};
            scel_pkg::ADDR_STATUS: rdata_d = {28'h0, led_arm_q, due_q};
            scel_pkg::ADDR_IRQ_STAT: rdata_d = {28'h0, ist_q};
            scel_pkg::ADDR_IRQ_MASK: rdata_d = {28'h0, imask_q};
            scel_pkg::ADDR_HIST_CNT: rdata_d = {25'h0, hcnt_q};
            scel_pkg::ADDR_HIST_IDX: rdata_d = {25'h0, hidx_q};
            scel_pkg::ADDR_HIST_DATA: begin
               if (hidx_q < hcnt_q) begin
                  rdata_d = {16'h0, hist_q[hidx_q]};
               end
            end
            scel_pkg::ADDR_CALLS: rdata_d = calls_q;
            scel_pkg::ADDR_DRIVES_STAT: rdata_d = dstat_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 3; i++) begin
            total_q[i] <= '0;
            cur_q[i] <= '0;
            rem_q[i] <= '0;
            ivl_q[i] <= scel_pkg::IVL_RESET;
         end
         hcnt_q <= '0;
         hidx_q <= '0;
         calls_q <= '0;
         dstat_q <= '0;
         ctrl_q <= scel_pkg::CTRL_RESET;
         ist_q <= '0;
         imask_q <= '0;
         flash_q <= '0;
         led_arm_q <= 1'b0;
         led_q <= 1'b0;
         due_q <= 3'h7;
         fwd_v_q <= 1'b0;
         fwd_c_q <= '0;
         rdata_q <= 32'h0;
         ack_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         total_q <= total_d;
         cur_q <= cur_d;
         rem_q <= rem_d;
         ivl_q <= ivl_d;
         hcnt_q <= hcnt_d;
         hidx_q <= hidx_d;
         calls_q <= calls_d;
         dstat_q <= dstat_d;
         ctrl_q <= ctrl_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         flash_q <= flash_d;
         led_arm_q <= led_arm_d;
         led_q <= led_d;
         due_q <= due_d;
         fwd_v_q <= fwd_v_d;
         fwd_c_q <= fwd_c_d;
         rdata_q <= rdata_d;
         ack_q <= ack_d;
         irq_q <= irq_d;
      end
   end

   // history memory has no reset; hcnt_q marks which entries are valid
   always_ff @(posedge clk_i) begin
      hist_q <= hist_d;
   end

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = !ack_q;
   assign service_due_o = due_q;
   assign err_fwd_valid_o = fwd_v_q;
   assign err_fwd_code_o = fwd_c_q;
   assign err_led_o = led_q;
   assign irq_o = irq_q;
endmodule

// *** dv/scel_lift_model.sv ***
module scel_lift_model (
   input wire logic clk_i,
   output scel_pkg::scel_evt_t evt_o,
   output scel_pkg::scel_err_t err_o
);
   initial begin
      evt_o = '0;
      err_o = '0;
   end
   // one-cycle event or error pulse, released at the next edge
   task automatic pulse(input scel_pkg::scel_evt_t e, input logic v,
                        input logic [scel_pkg::CODE_W-1:0] c);
      @(posedge clk_i);
      evt_o <= e;
      err_o <= {v, c};
      @(posedge clk_i);
      evt_o <= '0;
      err_o <= '0;
   endtask
endmodule

// *** dv/scel_top_monitor.sv ***
module scel_top_monitor (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire scel_pkg::scel_evt_t evt_i,
   input wire scel_pkg::scel_err_t err_i,
   input wire logic [2:0] service_due_o,
   input wire logic err_fwd_valid_o,
   input wire logic [scel_pkg::CODE_W-1:0] err_fwd_code_o,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic ev = |evt_i[3:1];
   wire logic cause = ev | err_i.valid | avs_write_i;
   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_ans;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   property p_ans;
      s_req |=> s_ans;
   endproperty
   property p_rd;
      $changed(avs_readdata_o) |-> $past(avs_read_i);
   endproperty
   property p_fwd;
      err_fwd_valid_o |-> $past(err_i.valid) &&
         err_fwd_code_o == $past(err_i.code);
   endproperty
   property p_due_rst;
      $fell(rst_i) |-> service_due_o == 3'h7;
   endproperty
   property p_due_up;
      |(service_due_o & ~$past(service_due_o)) |-> $past(ev) ||
         $past(ev, 2) || $past(avs_write_i, 2) || $past(avs_write_i, 3);
   endproperty
   property p_due_dn;
      |($past(service_due_o) & ~service_due_o) |-> $past(avs_write_i) ||
         $past(avs_write_i, 2) || $past(avs_write_i, 3);
   endproperty
   property p_irq_up;
      $rose(irq_o) |-> $past(cause) || $past(cause, 2) ||
         $past(cause, 3) || $past(cause, 4);
   endproperty
   property p_irq_dn;
      $fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2);
   endproperty
   a_ans: assert property (p_ans) else $error("answer not one cycle");
   a_rd: assert property (p_rd) else $error("read data moved");
   a_fwd: assert property (p_fwd) else $error("bad forward");
   a_due_rst: assert property (p_due_rst) else $error("due not set");
   a_due_up: assert property (p_due_up) else $error("due rose");
   a_due_dn: assert property (p_due_dn) else $error("due fell");
   a_irq_up: assert property (p_irq_up) else $error("irq rose");
   a_irq_dn: assert property (p_irq_dn) else $error("irq fell");
endmodule

bind scel_top scel_top_monitor mon_u (.clk_i, .rst_i, .avs_read_i,
   .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .evt_i, .err_i,
   .service_due_o, .err_fwd_valid_o, .err_fwd_code_o, .irq_o);

// *** dv/scel_top_tb_top.sv ***
module scel_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, rd = 0, wr = 0, wait_o, fv, led, irq;
   logic [7:0] addr = '0;
   logic [31:0] wd = '0, rdata, expq[$];
   logic [2:0] due;
   logic [15:0] fc;
   scel_pkg::scel_evt_t evt;
   scel_pkg::scel_err_t err;
   int n_mismatch = 0, n_checks = 0, cyc = 0, nfwd = 0;
   initial forever #20 clk_i = ~clk_i;
   scel_lift_model lift_u (.clk_i, .evt_o(evt), .err_o(err));
   scel_top dut_u (.clk_i, .rst_i, .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_o), .evt_i(evt), .err_i(err),
      .service_due_o(due), .err_fwd_valid_o(fv), .err_fwd_code_o(fc),
      .err_led_o(led), .irq_o(irq));
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      rd <= !w;
      wr <= w;
      addr <= a;
      wd <= d;
      do @(posedge clk_i); while (wait_o !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, '0);
   endtask
   task automatic err1(input logic [15:0] c);
      lift_u.pulse('0, 1'b1, c);
   endtask
   always @(posedge clk_i) begin
      if (rd === 1'b1 && wait_o === 1'b0) begin
         cmp(rdata, expq.pop_front());
      end
   end
   always @(negedge clk_i) begin
      if (fv === 1'b1) nfwd++;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 6000) begin
         n_mismatch++;
         summarize();
      end
   end
   initial begin
      logic [31:0] iv[3];
      logic [15:0] c[101];
      logic [7:0] o;
      int f;
      void'($urandom(32'h7866C627));
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      cmp({29'h0, due}, 32'h7);
      bus(1, scel_pkg::ADDR_IVL0, 32'h2710);
      rdx(scel_pkg::ADDR_IVL0, 32'h270F);
      bus(1, 8'h18, 32'h186A0);
      rdx(8'h18, 32'h1869F);
      for (int k = 0; k < 3; k++) begin
         iv[k] = 2 + $urandom % 4;
         bus(1, 8'(scel_pkg::ADDR_IVL0 + 4 * k), iv[k]);
      end
      bus(1, scel_pkg::ADDR_CMD, 32'h4);
      for (int k = 0; k < 3; k++) begin
         o = 8'(4 * k);
         rdx(scel_pkg::ADDR_REM0 + o, iv[k]);
         repeat (iv[k] - 1) lift_u.pulse(4'h8 >> k, 1'b0, '0);
         rdx(scel_pkg::ADDR_REM0 + o, 32'h1);
         cmp({31'h0, due[k]}, 32'h0);
         repeat (2) lift_u.pulse(4'h8 >> k, 1'b0, '0);
         rdx(scel_pkg::ADDR_REM0 + o, 32'h0);
         cmp({31'h0, due[k]}, 32'h1);
         rdx(scel_pkg::ADDR_CUR0 + o, iv[k] + 1);
         bus(1, scel_pkg::ADDR_TOTAL0 + o, 32'hFFFF);
         bus(1, scel_pkg::ADDR_CUR0 + o, 32'hFFFF);
      end
      bus(1, scel_pkg::ADDR_CMD, 32'h2);
      bus(1, scel_pkg::ADDR_CMD, 32'h4);
      for (int k = 0; k < 3; k++) begin
         o = 8'(4 * k);
         rdx(scel_pkg::ADDR_TOTAL0 + o, iv[k] + 1);
         rdx(scel_pkg::ADDR_CUR0 + o, 32'h0);
         rdx(scel_pkg::ADDR_REM0 + o, iv[k]);
      end
      rdx(8'hFC, 32'h0);
      bus(1, scel_pkg::ADDR_IRQ_MASK, 32'h8);
      @(negedge clk_i);
      cmp({31'h0, irq}, 32'h0);
      f = nfwd;
      err1(16'h1234);
      repeat (2) @(negedge clk_i);
      cmp({31'h0, irq}, 32'h1);
      rdx(scel_pkg::ADDR_IRQ_STAT, 32'hF);
      bus(1, scel_pkg::ADDR_IRQ_STAT, 32'hF);
      rdx(scel_pkg::ADDR_IRQ_STAT, 32'h0);
      cmp(nfwd - f, 32'h1);
      bus(1, scel_pkg::ADDR_CTRL, 32'h0);
      err1(16'h0055);
      repeat (3) @(negedge clk_i);
      cmp(nfwd - f, 32'h1);
      cmp({31'h0, led}, 32'h0);
      bus(1, scel_pkg::ADDR_CTRL, 32'h2);
      err1(16'h00AA);
      rdx(scel_pkg::ADDR_STATUS, 32'h8);
      bus(1, scel_pkg::ADDR_CMD, 32'h1);
      rdx(scel_pkg::ADDR_HIST_CNT, 32'h0);
      for (int i = 0; i < 101; i++) begin
         c[i] = 16'($urandom);
         err1(c[i]);
      end
      rdx(scel_pkg::ADDR_HIST_CNT, 32'd100);
      bus(1, scel_pkg::ADDR_HIST_IDX, 32'h0);
      rdx(scel_pkg::ADDR_HIST_DATA, {16'h0, c[100]});
      bus(1, scel_pkg::ADDR_HIST_IDX, 32'd99);
      rdx(scel_pkg::ADDR_HIST_DATA, {16'h0, c[1]});
      bus(1, scel_pkg::ADDR_CMD, 32'h1);
      rdx(scel_pkg::ADDR_HIST_CNT, 32'h0);
      repeat (2) lift_u.pulse(4'h1, 1'b0, '0);
      rdx(scel_pkg::ADDR_CALLS, 32'h2);
      bus(1, scel_pkg::ADDR_CMD, 32'h8);
      rdx(scel_pkg::ADDR_CALLS, 32'h0);
      rdx(scel_pkg::ADDR_DRIVES_STAT, 32'h0);
      summarize();
   end
endmodule
